// File: core/actuator_ctrl_status.sv
// Serial control word 0 and status word 0, upper fields, with mode and protection logic
// Operation
// RQ1: Enable zero gives standby, clears control; reset standby
// RQ2: Commit frame only after exactly 24 clocks
// RQ3: Status top bit always reads one
// RQ4: Clear command empties status at frame end
// RQ5: Restart on-ratio 12 or 25 percent
// RQ6: Over/undervoltage set bits, outputs switch off
// RQ7: Supply recovery automatic unless disable bit set
// RQ8: Thermal shutdown sets flag, all outputs off
// RQ9: Host clears thermal flag before outputs resume
// RQ10: Temperature warning is information only
// RQ11: Monitor select routes chosen driver current image
// RQ12: Standby to active sets not-ready, blocks outputs
// RQ13: Not-ready cleared by internal clock timer
module actuator_ctrl_status #(
  parameter int STARTUP_CYCLES = actuator_pkg::STARTUP_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic spi_sck,
  input wire logic select_low_pin,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  input wire logic load_supply_over,
  input wire logic load_supply_under,
  input wire logic thermal_trip_in,
  input wire logic temp_warning_in,
  input wire logic overload_current,
  input wire logic upper_switch_a_on,
  input wire logic upper_switch_f_on,
  output logic outputs_enable,
  output logic device_active,
  output logic restart_gate,
  output actuator_pkg::monitor_t current_sense_out
);
  startup_if tif ();

  startup_timer #(
    .CYCLES(STARTUP_CYCLES)
  ) u_timer (
    .mclk(mclk),
    .rst_b(rst_b),
    .tif(tif)
  );

  // Two-flop synchronisers; stage one feeds only stage two
  logic [9:0] pin_meta;
  logic [9:0] pin_sync;
  logic sck_prev;
  logic cs_prev;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      // Clock idles low and select idles high, so no false edge follows reset
      pin_meta <= 10'h002;
      pin_sync <= 10'h002;
      sck_prev <= 1'b0;
      cs_prev <= 1'b1;
    end
    else
    begin
      pin_meta <= {upper_switch_f_on, upper_switch_a_on, overload_current, temp_warning_in, thermal_trip_in,
                   load_supply_under, load_supply_over, spi_mosi, select_low_pin, spi_sck};
      pin_sync <= pin_meta;
      sck_prev <= pin_sync[0];
      cs_prev <= pin_sync[1];
    end
  end

  logic sck_s, cs_s, mosi_s, ov_s, uv_s, tsd_s, warn_s, oc_s, a_hs_s, f_hs_s;
  assign sck_s = pin_sync[0];
  assign cs_s = pin_sync[1];
  assign mosi_s = pin_sync[2];
  assign ov_s = pin_sync[3];
  assign uv_s = pin_sync[4];
  assign tsd_s = pin_sync[5];
  assign warn_s = pin_sync[6];
  assign oc_s = pin_sync[7];
  assign a_hs_s = pin_sync[8];
  assign f_hs_s = pin_sync[9];

  logic cs_low, cs_fall, cs_rise, sck_rise, sck_fall;
  assign cs_low = !cs_s;
  assign cs_fall = !cs_s && cs_prev;
  assign cs_rise = cs_s && !cs_prev;
  assign sck_rise = sck_s && !sck_prev;
  assign sck_fall = !sck_s && sck_prev;

  // Receive shifter, LSB first, with saturating pulse count
  logic [23:0] shift_in;
  logic [4:0] pulse_count;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      shift_in <= actuator_pkg::FRAME_RESET;
      pulse_count <= 5'h00;
    end
    else if (cs_fall)
    begin
      pulse_count <= 5'h00;
    end
    else if (cs_low && sck_rise)
    begin
      shift_in <= {mosi_s, shift_in[23:1]};
      if (pulse_count != actuator_pkg::COUNT_MAX)
        pulse_count <= pulse_count + 1'b1;
    end
  end

  logic accept;
  logic clear_status;
  assign accept = cs_rise && (pulse_count == actuator_pkg::FRAME_COUNT)
                  && !shift_in[actuator_pkg::BIT_SELECT]; // [RQ2]
  assign clear_status = accept && shift_in[actuator_pkg::BIT_CLEAR];

  // Control fields
  logic enable, duty_25, rec_dis;
  logic [1:0] mon_code;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      enable <= 1'b0;
      duty_25 <= 1'b0;
      rec_dis <= 1'b0;
      mon_code <= actuator_pkg::MON_CODE_RESET;
    end
    else if (accept)
    begin
      // Standby drops every control field, not only the enable
      if (shift_in[actuator_pkg::BIT_ENABLE]) // [RQ1]
      begin
        enable <= 1'b1;
        duty_25 <= shift_in[actuator_pkg::BIT_DUTY];
        rec_dis <= shift_in[actuator_pkg::BIT_REC_DIS];
        mon_code <= shift_in[actuator_pkg::BIT_MON_HI:actuator_pkg::BIT_MON_LO];
      end
      else
      begin
        enable <= 1'b0;
        duty_25 <= 1'b0;
        rec_dis <= 1'b0;
        mon_code <= actuator_pkg::MON_CODE_RESET;
      end
    end
  end

  // Mode control
  actuator_pkg::mode_t mode;
  assign tif.start = (mode == actuator_pkg::MODE_STANDBY) && enable; // [RQ12]
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      mode <= actuator_pkg::MODE_STANDBY;
    else
    begin
      case (mode)
        actuator_pkg::MODE_STANDBY:
          if (enable)
            mode <= actuator_pkg::MODE_STARTUP;
        actuator_pkg::MODE_STARTUP:
          if (!enable)
            mode <= actuator_pkg::MODE_STANDBY;
          else if (tif.done) // [RQ13]
            mode <= actuator_pkg::MODE_ACTIVE;
        actuator_pkg::MODE_ACTIVE:
          if (!enable)
            mode <= actuator_pkg::MODE_STANDBY;
        default:
          mode <= actuator_pkg::MODE_STANDBY;
      endcase
    end
  end

  // Sticky status; a fault present in the clearing cycle keeps its flag
  logic ov_flag, uv_flag, thermal_trip_flag, warn_flag;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ov_flag <= 1'b0;
      uv_flag <= 1'b0;
      thermal_trip_flag <= 1'b0;
      warn_flag <= 1'b0;
    end
    else
    begin
      ov_flag <= ov_s || (ov_flag && !clear_status); // [RQ6] [RQ4]
      uv_flag <= uv_s || (uv_flag && !clear_status); // [RQ6] [RQ4]
      thermal_trip_flag <= tsd_s || (thermal_trip_flag && !clear_status); // [RQ8] [RQ9]
      warn_flag <= warn_s || (warn_flag && !clear_status); // [RQ10]
    end
  end

  logic not_ready;
  assign not_ready = (mode == actuator_pkg::MODE_STARTUP); // [RQ12]

  function automatic logic [23:0] status_word(input logic [4:0] flags);
    logic [23:0] w;
    w = {1'b1, flags, 18'h00000}; // [RQ3]
    w[actuator_pkg::ST_NOERR] = ~|w[actuator_pkg::ST_LOW_TOP:1];
    return w;
  endfunction

  logic [23:0] status0;
  logic [23:0] status1;
  assign status0 = status_word({ov_flag, uv_flag, thermal_trip_flag, warn_flag, not_ready});
  assign status1 = {1'b1, 22'h000000, status0[actuator_pkg::ST_NOERR]};

  // Transmit: first rising clock loads the chosen word, falling clocks shift
  logic [23:0] shift_out;
  logic loaded;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      shift_out <= actuator_pkg::FRAME_RESET;
      loaded <= 1'b0;
    end
    else if (cs_fall)
      loaded <= 1'b0;
    else if (cs_low && sck_rise && !loaded)
    begin
      shift_out <= mosi_s ? status1 : status0;
      loaded <= 1'b1;
    end
    else if (cs_low && sck_fall && loaded)
      shift_out <= {1'b0, shift_out[23:1]};
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      spi_miso <= 1'b0;
      spi_miso_oe <= 1'b0;
    end
    else
    begin
      spi_miso <= loaded ? shift_out[0] : status0[actuator_pkg::ST_NOERR];
      spi_miso_oe <= cs_low;
    end
  end

  // Output gating; the warning flag deliberately takes no part
  logic supply_block;
  assign supply_block = ov_s || uv_s || (rec_dis && (ov_flag || uv_flag)); // [RQ7]
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      outputs_enable <= 1'b0;
      device_active <= 1'b0;
    end
    else
    begin
      outputs_enable <= (mode == actuator_pkg::MODE_ACTIVE) && !supply_block
                        && !tsd_s && !thermal_trip_flag; // [RQ6] [RQ8] [RQ12]
      device_active <= enable; // [RQ1]
    end
  end

  // Overload restart pattern, free running so all drivers share one phase
  logic [5:0] restart_phase;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      restart_phase <= actuator_pkg::RESTART_RESET;
      restart_gate <= 1'b1;
    end
    else
    begin
      restart_phase <= restart_phase + 1'b1;
      restart_gate <= !oc_s || (restart_phase < (duty_25 ? actuator_pkg::RESTART_ON_25
                                                        : actuator_pkg::RESTART_ON_12)); // [RQ5]
    end
  end

  // Monitor routing; code AF prefers A only when A's upper switch alone is on
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      current_sense_out <= actuator_pkg::MON_LARGE;
    else
    begin
      case (mon_code) // [RQ11]
        actuator_pkg::MON_CODE_LARGE: current_sense_out <= actuator_pkg::MON_LARGE;
        actuator_pkg::MON_CODE_E: current_sense_out <= actuator_pkg::MON_E;
        actuator_pkg::MON_CODE_AF: current_sense_out <= (a_hs_s && !f_hs_s) ? actuator_pkg::MON_A
                                                                           : actuator_pkg::MON_F;
        default: current_sense_out <= actuator_pkg::MON_D;
      endcase
    end
  end

  standby_clear_a: assert property (@(posedge mclk) disable iff (!rst_b) // [RQ1]
    accept && !shift_in[actuator_pkg::BIT_ENABLE] |=> !enable && !duty_25 && !rec_dis && (mon_code == 2'h0))
    else $error("standby frame left control fields set");
  frame_count_a: assert property (@(posedge mclk) disable iff (!rst_b) // [RQ2]
    cs_rise && (pulse_count != actuator_pkg::FRAME_COUNT) |=> $stable(enable) && $stable(mon_code))
    else $error("frame with wrong pulse count changed control");
  top_one_a: assert property (@(posedge mclk) disable iff (!rst_b) // [RQ3]
    cs_low && sck_rise && !loaded && !cs_fall |=> shift_out[23])
    else $error("returned word top bit not one");
  status_clear_a: assert property (@(posedge mclk) disable iff (!rst_b) // [RQ4]
    clear_status && !ov_s && !warn_s |=> !ov_flag && !warn_flag)
    else $error("clear command did not clear status");
  supply_off_a: assert property (@(posedge mclk) disable iff (!rst_b) // [RQ6]
    ov_s || uv_s |=> !outputs_enable && (ov_flag || uv_flag))
    else $error("supply fault left outputs on");
  supply_latch_a: assert property (@(posedge mclk) disable iff (!rst_b) // [RQ7]
    rec_dis && uv_flag && $past(uv_flag) |=> !outputs_enable)
    else $error("latched supply fault released outputs");
  thermal_off_a: assert property (@(posedge mclk) disable iff (!rst_b) // [RQ8]
    tsd_s |=> thermal_trip_flag && !outputs_enable)
    else $error("thermal trip left outputs on");
  startup_block_a: assert property (@(posedge mclk) disable iff (!rst_b) // [RQ12]
    tif.start |=> (not_ready && !outputs_enable) [*2])
    else $error("outputs active during start-up");
  monitor_e_a: assert property (@(posedge mclk) disable iff (!rst_b) // [RQ11]
    mon_code == actuator_pkg::MON_CODE_E && $stable(mon_code) |=> current_sense_out == actuator_pkg::MON_E)
    else $error("monitor code E routed wrong");
endmodule

// File: core/actuator_pkg.sv
// Constants, field positions and types for the actuator control and status bank
package actuator_pkg;
  // Frame layout
  localparam int FRAME_BITS = 24;
  localparam logic [4:0] FRAME_COUNT = 5'h18;
  localparam logic [4:0] COUNT_MAX = 5'h1F;
  localparam int BIT_SELECT = 0;
  localparam int BIT_ENABLE = 23;
  localparam int BIT_CLEAR = 22;
  localparam int BIT_DUTY = 21;
  localparam int BIT_REC_DIS = 20;
  localparam int BIT_MON_HI = 19;
  localparam int BIT_MON_LO = 18;
  // Status word layout
  localparam int ST_NOERR = 0;
  localparam int ST_LOW_TOP = 22;
  // Reset values
  localparam logic [23:0] FRAME_RESET = 24'h000000;
  localparam logic [1:0] MON_CODE_RESET = 2'h0;
  // Timing
  localparam int CLK_MHZ = 125;
  localparam int STARTUP_TIME_US = 100;
  localparam int STARTUP_CYCLES = STARTUP_TIME_US * CLK_MHZ;
  localparam int TIMER_W = 16;
  localparam logic [TIMER_W-1:0] TIMER_RESET = 16'h0000;
  // Overload restart pattern: period 64, on 8 (12.5 %) or 16 (25 %)
  localparam logic [5:0] RESTART_RESET = 6'h00;
  localparam logic [5:0] RESTART_ON_12 = 6'h08;
  localparam logic [5:0] RESTART_ON_25 = 6'h10;
  // Monitor codes
  localparam logic [1:0] MON_CODE_LARGE = 2'h0;
  localparam logic [1:0] MON_CODE_E = 2'h1;
  localparam logic [1:0] MON_CODE_AF = 2'h2;
  localparam logic [1:0] MON_CODE_D = 2'h3;

  typedef enum logic [1:0] {
    MODE_STANDBY = 2'h0,
    MODE_STARTUP = 2'h1,
    MODE_ACTIVE = 2'h3
  } mode_t;

  typedef enum logic [2:0] {
    MON_LARGE = 3'h0,
    MON_A = 3'h1,
    MON_F = 3'h2,
    MON_E = 3'h3,
    MON_D = 3'h4
  } monitor_t;
endpackage

// File: core/startup_if.sv
// Start and expiry handshake between mode control and the start-up timer
interface startup_if;
  logic start;
  logic done;
  modport owner (output start, input done);
  modport timer (input start, output done);
endinterface

// File: core/startup_timer.sv
// Start-up settling timer on the internal clock
module startup_timer #(
  parameter int CYCLES = actuator_pkg::STARTUP_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_b,
  startup_if.timer tif
);
  localparam logic [actuator_pkg::TIMER_W-1:0] LOAD = actuator_pkg::TIMER_W'(CYCLES - 1);

  logic [actuator_pkg::TIMER_W-1:0] remain;
  logic running;

  // A new start reloads, so a quick standby/active toggle restarts the full wait
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      remain <= actuator_pkg::TIMER_RESET;
      running <= 1'b0;
    end
    else if (tif.start)
    begin
      remain <= LOAD;
      running <= 1'b1;
    end
    else if (running)
    begin
      if (remain == actuator_pkg::TIMER_RESET)
        running <= 1'b0;
      else
        remain <= remain - 1'b1;
    end
  end

  assign tif.done = running && (remain == actuator_pkg::TIMER_RESET) && !tif.start;
endmodule

// File: dv/spi_host_model.sv
// Host SPI master model: mode 0, LSB first, clock idles low between frames
module spi_host_model
(
  input wire logic mclk,
  output logic sck,
  output logic cs_b,
  output logic mosi,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    sck = 1'b0;
    cs_b = 1'b1;
    mosi = 1'b0;
  end
  // Half of the 80 ns link period
  task automatic half();
    repeat (5) @(posedge mclk);
  endtask
  // Pulse counts other than 24 are sent on purpose to provoke a discard
  task automatic frame(input logic [23:0] wr, input int npulse, output logic [23:0] rd);
    rd = 24'h000000;
    @(posedge mclk);
    cs_b <= 1'b0;
    for (int i = 0; i < npulse; i++)
    begin
      mosi <= wr[i % 24];
      half();
      if (i < 24)
        rd[i] = miso;
      sck <= 1'b1;
      half();
      sck <= 1'b0;
    end
    half();
    cs_b <= 1'b1;
    // Released data line shows the inverse so a stale bit cannot pass as valid
    mosi <= ~wr[(npulse + 23) % 24];
    half();
  endtask
endmodule

// File: dv/test_actuator_ctrl_status_upper_bits.sv
// Self-checking bench for the actuator control and status bank
module test_actuator_ctrl_status_upper_bits;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SC = 400;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic sck, cs_b, mosi, miso, miso_oe, oe, act, gate;
  // Undriven data line shows the inverse, so a late output enable corrupts the read
  logic miso_line;
  assign miso_line = miso_oe ? miso : ~miso;
  logic [3:0] flt = 4'h0;
  logic olc = 1'b0;
  logic a_on = 1'b0;
  logic f_on = 1'b0;
  actuator_pkg::monitor_t mon;
  int n_errors = 0;
  int num_checks = 0;
  int m_en = 0;
  int m_rd = 0;
  int m_code = 0;
  int st_len = 0;
  int n;
  bit [3:0] fl = 4'h0;
  bit fnr = 1'b0;
  logic [23:0] rd;
  initial
  begin
    forever #4 mclk = ~mclk;
  end
  actuator_ctrl_status #(.STARTUP_CYCLES(SC)) i_actuator_ctrl_status (.mclk(mclk), .rst_b(rst_b),
    .spi_sck(sck), .select_low_pin(cs_b), .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(miso_oe),
    .load_supply_over(flt[0]), .load_supply_under(flt[1]), .thermal_trip_in(flt[2]),
    .temp_warning_in(flt[3]), .overload_current(olc), .upper_switch_a_on(a_on),
    .upper_switch_f_on(f_on), .outputs_enable(oe), .device_active(act), .restart_gate(gate),
    .current_sense_out(mon));
  spi_host_model i_spi_host_model (.mclk(mclk), .sck(sck), .cs_b(cs_b), .mosi(mosi), .miso(miso_line));
  // Length of the blocked span after each switch to active
  always @(posedge mclk)
    st_len <= (act && !oe) ? st_len + 1 : (act ? st_len : 0);
  task automatic test_done();
    $display("Checks %0d, errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  function automatic logic [2:0] exp_mon();
    if (m_en == 0)
      return actuator_pkg::MON_LARGE;
    case (m_code)
      0: return actuator_pkg::MON_LARGE;
      1: return actuator_pkg::MON_E;
      2: return (a_on && !f_on) ? actuator_pkg::MON_A : actuator_pkg::MON_F;
      default: return actuator_pkg::MON_D;
    endcase
  endfunction
  function automatic logic [23:0] exp_st();
    logic [23:0] s;
    s = {1'b1, fl[0], fl[1], fl[2], fl[3], fnr, 18'h00000};
    s[0] = ~|s[22:1];
    return s;
  endfunction
  task automatic cmp_outs();
    repeat (6) @(posedge mclk);
    check(act, m_en, "active");
    check(mon, exp_mon(), "monitor");
    check(oe, m_en != 0 && !fnr && !fl[2] && flt[1:0] == 2'h0 && !(m_rd != 0 && fl[1:0] != 2'h0), "outputs");
  endtask
  task automatic send(input int en, input int clr, input int duty, input int rdis, input int code, input int np);
    logic [23:0] w;
    logic [23:0] seen;
    w = {en[0], clr[0], duty[0], rdis[0], code[1:0], 17'($urandom), 1'b0};
    i_spi_host_model.frame(w, np, rd);
    // A short frame never clocks out its top bits, so only the bits read are compared
    seen = (np < 24) ? ((24'h000001 << np) - 24'h000001) : 24'hFFFFFF;
    check(rd & seen, exp_st() & seen, "status");
    if (np == 24)
    begin
      if (clr != 0)
        fl = flt;
      if (en != 0 && m_en == 0)
        fnr = 1'b1;
      m_en = en;
      m_code = en != 0 ? code : 0;
      m_rd = en != 0 ? rdis : 0;
    end
    cmp_outs();
  endtask
  task automatic fault(input int sel, input logic val);
    @(posedge mclk);
    flt[sel] <= val;
    if (val)
      fl[sel] = 1'b1;
    cmp_outs();
  endtask
  task automatic startup();
    send(1, 0, 0, 0, 0, 24);
    send(1, 0, 0, 0, 0, 24);
    n = 0;
    while (oe !== 1'b1 && n < 1000)
    begin
      @(posedge mclk);
      n++;
    end
    fnr = 1'b0;
    check(st_len >= SC && st_len <= SC + 4, 1'b1, "startup time");
    cmp_outs();
  endtask
  initial
  begin
    repeat (40000) @(posedge mclk);
    n_errors++;
    $display("Error at %0t: timeout", $time);
    test_done();
  end
  initial
  begin
    void'($urandom(32'h8020CFFA));
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    check({oe, act, gate, miso_oe, mon}, {4'h2, actuator_pkg::MON_LARGE}, "reset outputs");
    repeat (3) @(posedge mclk);
    startup();
    for (int i = 0; i < 16; i++)
    begin
      a_on <= i[2];
      f_on <= i[3];
      send(1, 0, 0, 0, i % 4, 24);
    end
    send(0, 0, 0, 0, 0, 23);
    send(0, 0, 0, 0, 0, 25);
    for (int d = 0; d < 2; d++)
    begin
      send(1, 0, d, 0, 0, 24);
      olc <= 1'b1;
      repeat (70) @(posedge mclk);
      n = 0;
      repeat (64) @(posedge mclk) n += (gate === 1'b1);
      check(n, d != 0 ? 16 : 8, "restart on-time");
      olc <= 1'b0;
    end
    fault(0, 1'b1);
    fault(0, 1'b0);
    send(1, 1, 0, 1, 0, 24);
    fault(1, 1'b1);
    fault(1, 1'b0);
    send(1, 1, 0, 0, 0, 24);
    fault(2, 1'b1);
    fault(2, 1'b0);
    send(1, 1, 0, 0, 0, 24);
    fault(3, 1'b1);
    send(1, 1, 0, 0, 0, 24);
    fault(3, 1'b0);
    send(1, 1, 0, 0, 0, 24);
    send(0, 0, 0, 0, 0, 24);
    startup();
    send(1, 0, 0, 0, 0, 24);
    test_done();
  end
endmodule
